// [common/csq_pkg.sv]
/*
 * Constants shared by the channel loss and mute control logic: register
 * offsets, field positions, reset values and the pre-emphasis decode.
 * Assumes a byte-addressed register port with 32-bit words.
 */
package csq_pkg;

   // ****************************************************************
   // Sizes
   // ****************************************************************
   localparam int CSQ_NCH = 12;
   localparam int CSQ_AW = 8;
   localparam int CSQ_DW = 32;
   localparam int CSQ_SWING_W = 2;
   localparam int CSQ_PRE_W = 3;
   localparam int CSQ_PRE_LO_NCH = 8;

   // ****************************************************************
   // Register offsets
   // ****************************************************************
   localparam logic [7:0] CSQ_OFF_CTRL = 8'h00;
   localparam logic [7:0] CSQ_OFF_MUTE_EN = 8'h04;
   localparam logic [7:0] CSQ_OFF_SWING = 8'h08;
   localparam logic [7:0] CSQ_OFF_PRE_LO = 8'h0c;
   localparam logic [7:0] CSQ_OFF_PRE_HI = 8'h10;
   localparam logic [7:0] CSQ_OFF_LOST_FLAG = 8'h14;
   localparam logic [7:0] CSQ_OFF_IRQ_MASK = 8'h18;
   localparam logic [7:0] CSQ_OFF_LIVE = 8'h1c;

   // ****************************************************************
   // Control register fields
   // ****************************************************************
   localparam int CSQ_CTRL_THR_LSB = 0;
   localparam int CSQ_CTRL_HYST = 2;
   localparam int CSQ_CTRL_POL_LOW = 3;
   localparam int CSQ_CTRL_DRAIN = 4;
   localparam int CSQ_CTRL_FORCE = 5;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [1:0] CSQ_RST_THR = 2'h0;
   localparam logic CSQ_RST_BIT = 1'h0;
   localparam logic [11:0] CSQ_RST_MUTE_EN = 12'hfff;
   localparam logic [23:0] CSQ_RST_SWING = 24'h000000;
   localparam logic [35:0] CSQ_RST_PRE = 36'h000000000;
   localparam logic [11:0] CSQ_RST_MASK = 12'h000;
   localparam logic [2:0] CSQ_PRE_OFF = 3'h0;

   // Zero is the disabled code; every other code peaks harder
   function automatic logic csq_pre_on(input logic [2:0] code);
      return code != CSQ_PRE_OFF;
   endfunction : csq_pre_on

endpackage : csq_pkg

// [common/csq_chan_if.sv]
/*
 * Per-channel configuration and live loss state, carried from the
 * register block to the channel output and pad driver modules.
 * Assumes a single driver, the register block, on the cfg side.
 */
`timescale 1ns/1ps
interface csq_chan_if;
   logic [11:0] los_live;
   logic [11:0] mute_en;
   logic force_test;
   logic [23:0] swing;
   logic [35:0] pre;
   logic pol_low;
   logic drain_style;

   modport cfg (output los_live, mute_en, force_test, swing, pre, pol_low, drain_style);
   modport sink (input los_live, mute_en, force_test, swing, pre, pol_low, drain_style);
endinterface : csq_chan_if

// [rtl/csq_chan_out.sv]
/*
 * Channel output controls: mute gating, swing and pre-emphasis codes.
 * Assumes mclk domain inputs; outputs are registered for the analog stage.
 */
`timescale 1ns/1ps
module csq_chan_out (
   input wire logic mclk,
   input wire logic rst,
   csq_chan_if.sink ifc,
   output logic [11:0] chan_mute,
   output logic [23:0] output_swing_sel,
   output logic [11:0] preemph_en,
   output logic [35:0] preemph_level
);
   typedef struct packed {
      logic [11:0] mute;
      logic [23:0] swing;
      logic [11:0] pre_en;
      logic [35:0] pre;
   } csq_chan_st_t;

   csq_chan_st_t st_r, st_nxt;
   logic [11:0] mute_w;
   logic [11:0] pre_on_w;

   genvar i;
   generate
      for (i = 0; i < csq_pkg::CSQ_NCH; i++) begin : g_ch
         assign mute_w[i] = ifc.mute_en[i] & (ifc.los_live[i] | ifc.force_test);
         assign pre_on_w[i] = csq_pkg::csq_pre_on(ifc.pre[i*3 +: 3]);
      end
   endgenerate

   always_comb begin
      st_nxt = st_r;
      st_nxt.mute = mute_w;
      st_nxt.swing = ifc.swing;
      st_nxt.pre_en = pre_on_w;
      st_nxt.pre = ifc.pre;
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st_r <= '{12'h000, csq_pkg::CSQ_RST_SWING, 12'h000, csq_pkg::CSQ_RST_PRE};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign chan_mute = st_r.mute;
   assign output_swing_sel = st_r.swing;
   assign preemph_en = st_r.pre_en;
   assign preemph_level = st_r.pre;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   mute_on_loss_a: assert property (
      (ifc.los_live & ifc.mute_en) != 12'h000 |=> (chan_mute & $past(ifc.los_live & ifc.mute_en))
         == $past(ifc.los_live & ifc.mute_en))
      else $error("muted channel with lost signal not forced low");
   mute_off_a: assert property (
      ##1 (chan_mute & ~$past(ifc.mute_en)) == 12'h000)
      else $error("mute applied to channel with mute disabled");
   mute_force_a: assert property (
      ifc.force_test |=> chan_mute == $past(ifc.mute_en))
      else $error("test force did not mute every enabled channel");
   pre_zero_a: assert property (
      ifc.pre == csq_pkg::CSQ_RST_PRE |=> preemph_en == 12'h000)
      else $error("pre-emphasis enabled with all codes zero");
endmodule : csq_chan_out

// [rtl/csq_pad_drv.sv]
/*
 * Detect and loss pad drivers with selectable polarity; drain style selectable on the detect pads only.
 * Assumes the pad ring resolves the wire level from output and enable.
 */
`timescale 1ns/1ps
module csq_pad_drv (
   input wire logic mclk,
   input wire logic rst,
   csq_chan_if.sink ifc,
   output logic [11:0] signal_detect_pad,
   output logic [11:0] signal_detect_pad_oe,
   output logic loss_pad,
   output logic loss_pad_oe
);
   typedef struct packed {
      logic [11:0] det_o;
      logic [11:0] det_oe;
      logic loss_o;
   } csq_pad_st_t;

   csq_pad_st_t st_r, st_nxt;
   logic [11:0] level_w;

   always_comb begin
      st_nxt = st_r;
      level_w = ~ifc.los_live ^ {12{ifc.pol_low}};
      // open drain only pulls toward zero
      if (ifc.drain_style) begin
         st_nxt.det_o = 12'h000;
         st_nxt.det_oe = ~level_w;
      end else begin
         st_nxt.det_o = level_w;
         st_nxt.det_oe = 12'hfff;
      end
      // loss pad follows the live condition
      st_nxt.loss_o = (|ifc.los_live) ^ ifc.pol_low;
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st_r <= '{12'h000, 12'h000, 1'h0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign signal_detect_pad = st_r.det_o;
   assign signal_detect_pad_oe = st_r.det_oe;
   assign loss_pad = st_r.loss_o;
   assign loss_pad_oe = 1'b1;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   loss_pad_live_a: assert property (
      ##1 loss_pad == ($past(|ifc.los_live) ^ $past(ifc.pol_low)))
      else $error("loss pad does not follow live loss condition");
   drain_low_a: assert property (
      ifc.drain_style |=> signal_detect_pad == 12'h000)
      else $error("open-drain detect pad driven high");
endmodule : csq_pad_drv

// [rtl/csq_top.sv]
/*
 * Twelve-channel loss-of-signal and mute control with its register file.
 * Holds the registers, sticky loss flags and interrupt, and instantiates
 * the channel output and pad driver modules.
 * Assumes all inputs synchronous to mclk and a master that never overlaps
 * read and write strobes.
 */
// Overview of operation
// - Each of twelve channels has its own loss comparator input.
// - Two-bit threshold select and one hysteresis boost bit drive the detectors.
// - Loss on a channel drives the loss pad and sets its sticky flag.
// - The loss pad follows the live condition and drops on recovery.
// - Sticky flags stay set until software clears them by writing ones.
// - A control bit selects the active level of the detect and loss pads.
// - A control bit makes the detect pads open-drain instead of push-pull.
// - A muted channel with lost signal is forced to logic zero.
// - Each channel has a mute enable; clearing it stops the forcing.
// - A test bit forces all mute-enabled channels to zero.
// - Each channel has a two-bit output swing code.
// - Each channel has a three-bit pre-emphasis code, one code disabled.
`timescale 1ns/1ps
module csq_top (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic [11:0] los_cmp,
   output logic [1:0] los_threshold_sel,
   output logic los_hysteresis_boost,
   output logic [11:0] chan_mute,
   output logic [23:0] output_swing_sel,
   output logic [11:0] preemph_en,
   output logic [35:0] preemph_level,
   output logic [11:0] signal_detect_pad,
   output logic [11:0] signal_detect_pad_oe,
   output logic loss_pad,
   output logic loss_pad_oe,
   output logic irq
);

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      logic [1:0] thr;
      logic hyst;
      logic pol_low;
      logic drain;
      logic force_test;
      logic [11:0] mute_en;
      logic [23:0] swing;
      logic [35:0] pre;
      logic [11:0] lost;
      logic [11:0] mask;
      logic [31:0] rdata;
      logic irq;
   } csq_top_st_t;

   csq_top_st_t st_r, st_nxt;
   logic [11:0] clr_w;
   logic [31:0] rd_val;

   csq_chan_if u_if ();

   // ****************************************************************
   // Address decode
   // ****************************************************************
   function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
      return addr == off;
   endfunction : hit

   // ****************************************************************
   // Read mux
   // ****************************************************************
   always_comb begin
      rd_val = 32'h00000000;
      case (reg_addr)
         csq_pkg::CSQ_OFF_CTRL: begin
            rd_val[csq_pkg::CSQ_CTRL_THR_LSB +: 2] = st_r.thr;
            rd_val[csq_pkg::CSQ_CTRL_HYST] = st_r.hyst;
            rd_val[csq_pkg::CSQ_CTRL_POL_LOW] = st_r.pol_low;
            rd_val[csq_pkg::CSQ_CTRL_DRAIN] = st_r.drain;
            rd_val[csq_pkg::CSQ_CTRL_FORCE] = st_r.force_test;
         end
         csq_pkg::CSQ_OFF_MUTE_EN: begin
            rd_val[11:0] = st_r.mute_en;
         end
         csq_pkg::CSQ_OFF_SWING: begin
            rd_val[23:0] = st_r.swing;
         end
         csq_pkg::CSQ_OFF_PRE_LO: begin
            rd_val[23:0] = st_r.pre[23:0];
         end
         csq_pkg::CSQ_OFF_PRE_HI: begin
            rd_val[11:0] = st_r.pre[35:24];
         end
         csq_pkg::CSQ_OFF_LOST_FLAG: begin
            rd_val[11:0] = st_r.lost;
         end
         csq_pkg::CSQ_OFF_IRQ_MASK: begin
            rd_val[11:0] = st_r.mask;
         end
         csq_pkg::CSQ_OFF_LIVE: begin
            rd_val[11:0] = los_cmp;
         end
         // Unmapped offsets read as zero
         default: begin
            rd_val = 32'h00000000;
         end
      endcase
   end

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      st_nxt = st_r;
      clr_w = 12'h000;
      if (reg_wr) begin
         if (hit(reg_addr, csq_pkg::CSQ_OFF_CTRL)) begin
            st_nxt.thr = reg_wdata[csq_pkg::CSQ_CTRL_THR_LSB +: 2];
            st_nxt.hyst = reg_wdata[csq_pkg::CSQ_CTRL_HYST];
            st_nxt.pol_low = reg_wdata[csq_pkg::CSQ_CTRL_POL_LOW];
            st_nxt.drain = reg_wdata[csq_pkg::CSQ_CTRL_DRAIN];
            st_nxt.force_test = reg_wdata[csq_pkg::CSQ_CTRL_FORCE];
         end
         if (hit(reg_addr, csq_pkg::CSQ_OFF_MUTE_EN)) begin
            st_nxt.mute_en = reg_wdata[11:0];
         end
         // swing codes, two bits per channel
         if (hit(reg_addr, csq_pkg::CSQ_OFF_SWING)) begin
            st_nxt.swing = reg_wdata[23:0];
         end
         // pre-emphasis codes split over two words
         if (hit(reg_addr, csq_pkg::CSQ_OFF_PRE_LO)) begin
            st_nxt.pre[23:0] = reg_wdata[23:0];
         end
         if (hit(reg_addr, csq_pkg::CSQ_OFF_PRE_HI)) begin
            st_nxt.pre[35:24] = reg_wdata[11:0];
         end
         if (hit(reg_addr, csq_pkg::CSQ_OFF_LOST_FLAG)) begin
            clr_w = reg_wdata[11:0];
         end
         if (hit(reg_addr, csq_pkg::CSQ_OFF_IRQ_MASK)) begin
            st_nxt.mask = reg_wdata[11:0];
         end
      end
      // sticky set beats a same-cycle clear so no loss is missed
      st_nxt.lost = (st_r.lost & ~clr_w) | los_cmp;
      st_nxt.rdata = reg_rd ? rd_val : 32'h00000000;
      st_nxt.irq = |(st_r.lost & st_r.mask);
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st_r.thr <= csq_pkg::CSQ_RST_THR;
         st_r.hyst <= csq_pkg::CSQ_RST_BIT;
         st_r.pol_low <= csq_pkg::CSQ_RST_BIT;
         st_r.drain <= csq_pkg::CSQ_RST_BIT;
         st_r.force_test <= csq_pkg::CSQ_RST_BIT;
         st_r.mute_en <= csq_pkg::CSQ_RST_MUTE_EN;
         st_r.swing <= csq_pkg::CSQ_RST_SWING;
         st_r.pre <= csq_pkg::CSQ_RST_PRE;
         st_r.lost <= 12'h000;
         st_r.mask <= csq_pkg::CSQ_RST_MASK;
         st_r.rdata <= 32'h00000000;
         st_r.irq <= 1'h0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ****************************************************************
   // Outputs and channel bundle
   // ****************************************************************
   assign reg_rdata = st_r.rdata;
   // controls handed to the analog detectors
   assign los_threshold_sel = st_r.thr;
   assign los_hysteresis_boost = st_r.hyst;
   assign irq = st_r.irq;

   assign u_if.los_live = los_cmp;
   assign u_if.mute_en = st_r.mute_en;
   assign u_if.force_test = st_r.force_test;
   assign u_if.swing = st_r.swing;
   assign u_if.pre = st_r.pre;
   assign u_if.pol_low = st_r.pol_low;
   assign u_if.drain_style = st_r.drain;

   csq_chan_out u_chan (
      .mclk(mclk),
      .rst(rst),
      .ifc(u_if.sink),
      .chan_mute(chan_mute),
      .output_swing_sel(output_swing_sel),
      .preemph_en(preemph_en),
      .preemph_level(preemph_level)
   );

   csq_pad_drv u_pad (
      .mclk(mclk),
      .rst(rst),
      .ifc(u_if.sink),
      .signal_detect_pad(signal_detect_pad),
      .signal_detect_pad_oe(signal_detect_pad_oe),
      .loss_pad(loss_pad),
      .loss_pad_oe(loss_pad_oe)
   );

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   lost_flag_set_a: assert property (
      los_cmp != 12'h000 |=> (st_r.lost & $past(los_cmp)) == $past(los_cmp))
      else $error("loss did not set its sticky flag");

   lost_flag_hold_a: assert property (
      !(reg_wr && reg_addr == csq_pkg::CSQ_OFF_LOST_FLAG)
         |=> (st_r.lost & $past(st_r.lost)) == $past(st_r.lost))
      else $error("sticky flag dropped without a clear write");

   lost_flag_clear_a: assert property (
      reg_wr && reg_addr == csq_pkg::CSQ_OFF_LOST_FLAG && los_cmp == 12'h000
         |=> (st_r.lost & $past(reg_wdata[11:0])) == 12'h000)
      else $error("write of one did not clear sticky flag");

   thr_write_a: assert property (
      reg_wr && reg_addr == csq_pkg::CSQ_OFF_CTRL
         |=> los_threshold_sel == $past(reg_wdata[1:0])
            && los_hysteresis_boost == $past(reg_wdata[2]))
      else $error("threshold or hysteresis not taken from write");

   irq_level_a: assert property (
      ##1 irq == $past(|(st_r.lost & st_r.mask)))
      else $error("interrupt does not match masked sticky flags");

   read_slot_a: assert property (
      !reg_rd |=> reg_rdata == 32'h00000000)
      else $error("read data present outside the read slot");

   swing_write_a: assert property (
      reg_wr && reg_addr == csq_pkg::CSQ_OFF_SWING
         |=> ##1 output_swing_sel == $past(reg_wdata[23:0], 2))
      else $error("swing code did not reach channel outputs");

   pre_hi_write_a: assert property (
      reg_wr && reg_addr == csq_pkg::CSQ_OFF_PRE_HI
         |=> ##1 preemph_level[35:24] == $past(reg_wdata[11:0], 2))
      else $error("upper pre-emphasis codes not applied");

   polarity_loss_a: assert property (
      $stable(st_r.pol_low) && los_cmp != 12'h000 |=> loss_pad == !$past(st_r.pol_low))
      else $error("loss pad active level ignores polarity bit");

endmodule : csq_top

// [testbench/csq_front_model.sv]
/*
 * Far-side model: per-channel loss comparators and the pad ring.
 * Assumes the bench changes lost_req by non-blocking assignment at mclk.
 */
`timescale 1ns/1ps
module csq_front_model (
   input wire logic mclk,
   input wire logic [11:0] lost_req,
   output logic [11:0] los_cmp,
   input wire logic [11:0] signal_detect_pad,
   input wire logic [11:0] signal_detect_pad_oe,
   input wire logic loss_pad,
   input wire logic loss_pad_oe,
   output logic [11:0] detect_wire,
   output logic loss_wire
);
   initial los_cmp = 12'h000;
   always @(posedge mclk) los_cmp <= lost_req;

   // pull-up on a released pad, so a missing drive never reads as low
   always_comb begin
      for (int i = 0; i < 12; i++) begin
         detect_wire[i] = signal_detect_pad_oe[i] ? signal_detect_pad[i] : 1'b1;
      end
      loss_wire = loss_pad_oe ? loss_pad : 1'b1;
   end
endmodule : csq_front_model

// [testbench/channel_los_squelch_control_test.sv]
/*
 * Self-checking bench for the loss, mute and output control block.
 * Assumes csq_pkg, csq_chan_if and the rtl files are compiled before it.
 */
`timescale 1ns/1ps
module channel_los_squelch_control_test;
   localparam logic [7:0] A_CTRL = csq_pkg::CSQ_OFF_CTRL;
   localparam logic [7:0] A_MUTE = csq_pkg::CSQ_OFF_MUTE_EN;
   localparam logic [7:0] A_FLAG = csq_pkg::CSQ_OFF_LOST_FLAG;
   localparam logic [7:0] A_MASK = csq_pkg::CSQ_OFF_IRQ_MASK;
   localparam logic [7:0] A_LIVE = csq_pkg::CSQ_OFF_LIVE;
   logic mclk, rst, reg_wr, reg_rd, irq, loss_o, loss_oe, hyst, loss_wire;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   logic [11:0] los_cmp, lost_req, mute, pre_en, det_o, det_oe, det_wire, en_exp;
   logic [1:0] thr;
   logic [23:0] swing;
   logic [35:0] pre_lvl, pre_exp;
   logic [2:0] code;
   int err_count, n_compared;

   csq_top uut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .los_cmp(los_cmp),
      .los_threshold_sel(thr), .los_hysteresis_boost(hyst), .chan_mute(mute),
      .output_swing_sel(swing), .preemph_en(pre_en), .preemph_level(pre_lvl),
      .signal_detect_pad(det_o), .signal_detect_pad_oe(det_oe), .loss_pad(loss_o),
      .loss_pad_oe(loss_oe), .irq(irq));

   csq_front_model far (.mclk(mclk), .lost_req(lost_req), .los_cmp(los_cmp),
      .signal_detect_pad(det_o), .signal_detect_pad_oe(det_oe), .loss_pad(loss_o),
      .loss_pad_oe(loss_oe), .detect_wire(det_wire), .loss_wire(loss_wire));

   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   // ****************************************************************
   // Bus and compare tasks
   // ****************************************************************
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : tick

   task automatic setl(input logic [11:0] v);
      @(posedge mclk);
      lost_req <= v;
   endtask : setl

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic chk(input logic [35:0] g, input logic [35:0] e);
      n_compared++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk

   // Read data stand only in the cycle after the strobe
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      chk({4'h0, reg_rdata}, {4'h0, e});
   endtask : rd_chk

   task automatic done(input string s);
      $display("test %s done", s);
   endtask : done

   task automatic complete_run;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : complete_run

   initial begin
      repeat (20000) @(posedge mclk);
      err_count++;
      $display("run cut short by watchdog");
      complete_run();
   end

   // ****************************************************************
   // Test sequence
   // ****************************************************************
   initial begin
      rst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h00000000;
      lost_req = 12'h000;
      err_count = 0;
      n_compared = 0;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      tick(2);
      rd_chk(A_CTRL, 32'h00000000);
      rd_chk(A_MUTE, 32'h00000fff);
      rd_chk(A_MASK, 32'h00000000);
      rd_chk(A_FLAG, 32'h00000000);
      chk(det_wire, 12'hfff);
      done("reset");
      for (int t = 0; t < 4; t++) begin
         wr(A_CTRL, t | 32'h4);
         tick(2);
         chk(thr, t);
         chk(hyst, 1'b1);
      end
      wr(A_CTRL, 32'h00000000);
      tick(2);
      chk(hyst, 1'b0);
      done("threshold");
      // Loss, sticky flag and masked interrupt
      wr(A_MASK, 32'h00000008);
      setl(12'h008);
      tick(4);
      chk(mute, 12'h008);
      chk(loss_wire, 1'b1);
      chk(det_wire, 12'hff7);
      chk(irq, 1'b1);
      wr(A_FLAG, 32'h00000008);
      rd_chk(A_FLAG, 32'h00000008);
      setl(12'h000);
      tick(4);
      chk(mute, 12'h000);
      chk(loss_wire, 1'b0);
      chk(det_wire, 12'hfff);
      chk(irq, 1'b1);
      rd_chk(A_FLAG, 32'h00000008);
      wr(A_FLAG, 32'h00000008);
      tick(3);
      chk(irq, 1'b0);
      rd_chk(A_FLAG, 32'h00000000);
      setl(12'h020);
      tick(4);
      chk(irq, 1'b0);
      rd_chk(A_FLAG, 32'h00000020);
      rd_chk(A_LIVE, 32'h00000020);
      wr(A_MASK, 32'h00000028);
      tick(3);
      chk(irq, 1'b1);
      setl(12'h000);
      wr(A_FLAG, 32'h00000fff);
      tick(3);
      chk(irq, 1'b0);
      done("loss");
      // Mute enable and forced mute test
      setl(12'h008);
      wr(A_MUTE, 32'h00000000);
      tick(3);
      chk(mute, 12'h000);
      wr(A_MUTE, 32'h00000fff);
      tick(3);
      chk(mute, 12'h008);
      setl(12'h000);
      wr(A_MUTE, 32'h000000a5);
      wr(A_CTRL, 32'h00000020);
      tick(3);
      chk(mute, 12'h0a5);
      wr(A_CTRL, 32'h00000000);
      tick(3);
      chk(mute, 12'h000);
      done("mute");
      // Pad polarity and drain style
      setl(12'h001);
      wr(A_CTRL, 32'h00000008);
      tick(3);
      chk(loss_wire, 1'b0);
      chk(det_wire, 12'h001);
      wr(A_CTRL, 32'h00000010);
      tick(3);
      chk(det_o, 12'h000);
      chk(det_wire, 12'hffe);
      chk(loss_wire, 1'b1);
      wr(A_CTRL, 32'h00000018);
      tick(3);
      chk(det_oe, 12'hffe);
      chk(det_wire, 12'h001);
      setl(12'h000);
      wr(A_CTRL, 32'h00000000);
      wr(A_FLAG, 32'h00000fff);
      done("pads");
      // Swing and every pre-emphasis code
      pre_exp = 36'h000000000;
      en_exp = 12'h000;
      for (int i = 0; i < 12; i++) begin
         code = 3'((i * 3) % 8);
         pre_exp[3 * i +: 3] = code;
         en_exp[i] = (code != 3'h0);
      end
      wr(csq_pkg::CSQ_OFF_SWING, 32'h00e41b93);
      wr(csq_pkg::CSQ_OFF_PRE_LO, {8'h00, pre_exp[23:0]});
      wr(csq_pkg::CSQ_OFF_PRE_HI, {20'h00000, pre_exp[35:24]});
      tick(3);
      chk(swing, 24'he41b93);
      chk(pre_lvl, pre_exp);
      chk(pre_en, en_exp);
      rd_chk(csq_pkg::CSQ_OFF_SWING, 32'h00e41b93);
      done("outputs");
      // Unmapped and read-only places
      rd_chk(8'h20, 32'h00000000);
      wr(8'h20, 32'hffffffff);
      wr(A_LIVE, 32'h00000fff);
      rd_chk(A_CTRL, 32'h00000000);
      rd_chk(A_LIVE, 32'h00000000);
      rd_chk(A_MUTE, 32'h000000a5);
      done("refusal");
      complete_run();
   end
endmodule : channel_los_squelch_control_test
